// [rtl/hoist_consts.vh]
// Constants for the hoist lift safety sequencer: timing, register map, field layout.
// Assumes inclusion by bare name; definitions only.
`ifndef HOIST_CONSTS_VH
`define HOIST_CONSTS_VH

// Clock and millisecond tick
`define CLK_PERIOD_NS 5
`define MS_NS 1000000

// Persistence and acknowledge times in ms
`define OVL_PERSIST_MS 12'h320
`define OVL_ACK_MS 12'h7D0

// Delay table rows in ms: longest row, codes 1-3, 4-5, 6 and A
`define ROW0_SLOW_OFF 12'h258
`define ROW0_FAST_OFF 12'h4E2
`define ROW0_REV_OFF 12'h4E2
`define ROW0_START 12'h1F4
`define ROW0_STOP 12'h1F4
`define ROW1_SLOW_OFF 12'h0FA
`define ROW1_FAST_OFF 12'h1F4
`define ROW1_REV_OFF 12'h1F4
`define ROW1_START 12'h000
`define ROW1_STOP 12'h0FA
`define ROW4_SLOW_OFF 12'h190
`define ROW4_FAST_OFF 12'h2EE
`define ROW4_REV_OFF 12'h2EE
`define ROW4_START 12'h12C
`define ROW4_STOP 12'h12C
`define ROW6_SLOW_OFF 12'h190
`define ROW6_FAST_OFF 12'h2EE
`define ROW6_REV_OFF 12'h2EE
`define ROW6_START 12'h190
`define ROW6_STOP 12'h190
`define ROWA_SLOW_OFF 12'h190
`define ROWA_FAST_OFF 12'h2EE
`define ROWA_REV_OFF 12'h2EE
`define ROWA_START 12'h000
`define ROWA_STOP 12'h000
`define DLY_NONE 12'h000

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_ERROR 8'h08

// Control register fields and reset value
`define CTRL_SEL_LSB 0
`define CTRL_SEL_MSB 3
`define CTRL_TABLE_BIT 4
`define CTRL_RESET 5'h00

// Status register fields
`define ST_LIFT_SLOW 0
`define ST_LIFT_FAST 1
`define ST_LOWER_SLOW 2
`define ST_LOWER_FAST 3
`define ST_OVERLOAD 4
`define ST_SENSOR_ERR 5
`define ST_OVERTEMP 6
`define ST_CHAN_DIFF 7
`define ST_STATE_LSB 8

// Sensor error codes
`define ERR_NONE 2'h0
`define ERR_OPEN 2'h1
`define ERR_SHORT 2'h2
`define ERR_MISMATCH 2'h3

`endif

// [rtl/hoist_lift_safety_sequencer.v]
// Hoist lift/lower relay sequencer with overload, sensor-fault and motor-management timing.
// Assumes pendant inputs are asynchronous pins; load and sensor indications arrive
// synchronous to clk_i; registers reached over a single-slave AHB-Lite bus.
`timescale 1ns/1ps
`include "hoist_consts.vh"

module hoist_lift_safety_sequencer #(
  parameter MS_CYCLES = `MS_NS / `CLK_PERIOD_NS
) (
  input wire clk_i,
  input wire rst_i,
  input wire lift_req_a_i,
  input wire lift_req_b_i,
  input wire lower_req_a_i,
  input wire lower_req_b_i,
  input wire fast_req_i,
  input wire over_threshold_i,
  input wire below_ack_level_i,
  input wire cable_open_i,
  input wire input_short_i,
  input wire channel_mismatch_i,
  input wire sensor_in_limits_i,
  input wire overtemp_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output wire [31:0] hrdata_o,
  output wire hreadyout_o,
  output wire hresp_o,
  output wire lift_slow_o,
  output wire lift_fast_o,
  output wire lower_slow_o,
  output wire lower_fast_o
);

  localparam ST_IDLE = 3'h0;
  localparam ST_SLOW = 3'h1;
  localparam ST_FAST = 3'h2;
  localparam ST_STOP = 3'h3;
  localparam ST_OFF = 3'h4;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, two stages each

  reg [4:0] sync1_ff;
  reg [4:0] sync2_ff;
  wire [4:0] pins = {fast_req_i, lower_req_b_i, lower_req_a_i, lift_req_b_i, lift_req_a_i};

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_ff <= 5'h00;
      sync2_ff <= 5'h00;
    end else begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
    end
  end

  // Both channels must agree before a request counts
  wire lift_req = sync2_ff[0] & sync2_ff[1];
  wire lower_req = sync2_ff[2] & sync2_ff[3];
  wire chan_diff = (sync2_ff[0] ^ sync2_ff[1]) | (sync2_ff[2] ^ sync2_ff[3]);
  wire fast_raw = sync2_ff[4];

  ////////////////////////////////////////////////////////////////////////////////
  // Millisecond tick

  reg [17:0] div_ff;
  reg tick_ff;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_ff <= 18'h00000;
      tick_ff <= 1'b0;
    end else if (div_ff == MS_CYCLES[17:0] - 18'h00001) begin
      div_ff <= 18'h00000;
      tick_ff <= 1'b1;
    end else begin
      div_ff <= div_ff + 18'h00001;
      tick_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control register and delay table

  reg [4:0] ctrl_ff;
  wire [3:0] motor_type_selector = ctrl_ff[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
  wire timing_table_bit = ctrl_ff[`CTRL_TABLE_BIT];
  reg [11:0] slow_off_time;
  reg [11:0] fast_off_time;
  reg [11:0] reversal_off_time;
  reg [11:0] slow_start_delay;
  reg [11:0] slow_stop_delay;

  always @* begin
    slow_off_time = `ROW0_SLOW_OFF;
    fast_off_time = `ROW0_FAST_OFF;
    reversal_off_time = `ROW0_REV_OFF;
    slow_start_delay = `ROW0_START;
    slow_stop_delay = `ROW0_STOP;
    case (motor_type_selector)
      4'h1, 4'h2, 4'h3: begin
        slow_off_time = `ROW1_SLOW_OFF;
        fast_off_time = `ROW1_FAST_OFF;
        reversal_off_time = `ROW1_REV_OFF;
        slow_start_delay = `ROW1_START;
        slow_stop_delay = `ROW1_STOP;
      end
      4'h4, 4'h5: begin
        slow_off_time = `ROW4_SLOW_OFF;
        fast_off_time = `ROW4_FAST_OFF;
        reversal_off_time = `ROW4_REV_OFF;
        slow_start_delay = `ROW4_START;
        slow_stop_delay = `ROW4_STOP;
      end
      4'h6: begin
        slow_off_time = `ROW6_SLOW_OFF;
        fast_off_time = `ROW6_FAST_OFF;
        reversal_off_time = `ROW6_REV_OFF;
        slow_start_delay = `ROW6_START;
        slow_stop_delay = `ROW6_STOP;
      end
      4'hA: begin
        slow_off_time = `ROWA_SLOW_OFF;
        fast_off_time = `ROWA_FAST_OFF;
        reversal_off_time = `ROWA_REV_OFF;
        slow_start_delay = `ROWA_START;
        slow_stop_delay = `ROWA_STOP;
      end
      4'hF: begin
        // Inverter setting needs the table bit on, otherwise longest values apply
        if (timing_table_bit) begin
          slow_off_time = `DLY_NONE;
          fast_off_time = `DLY_NONE;
          reversal_off_time = `DLY_NONE;
          slow_start_delay = `DLY_NONE;
          slow_stop_delay = `DLY_NONE;
        end
      end
      default: begin
        // Codes 0, 7, 8-9 and B-E keep the longest values
        slow_off_time = `ROW0_SLOW_OFF;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Overload detection

  reg overload_ff;
  reg [11:0] persist_ff;
  reg [11:0] ack_ff;
  wire persist_done = persist_ff >= `OVL_PERSIST_MS;
  wire ack_done = ack_ff >= `OVL_ACK_MS;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      overload_ff <= 1'b0;
      persist_ff <= 12'h000;
      ack_ff <= 12'h000;
    end else begin
      if (!over_threshold_i || lift_req) begin
        persist_ff <= 12'h000;
      end else if (tick_ff && !persist_done) begin
        persist_ff <= persist_ff + 12'h001;
      end
      if (!(below_ack_level_i && lower_req)) begin
        ack_ff <= 12'h000;
      end else if (tick_ff && !ack_done) begin
        ack_ff <= ack_ff + 12'h001;
      end
      if (over_threshold_i && lift_req) begin
        overload_ff <= 1'b1;
      end else if (over_threshold_i && persist_done) begin
        overload_ff <= 1'b1;
      end else if (ack_done && !over_threshold_i) begin
        overload_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sensor fault detection and error code

  reg sensor_err_ff;
  reg [1:0] err_code_ff;
  wire any_fault = cable_open_i | input_short_i | channel_mismatch_i;
  wire [1:0] fault_code = cable_open_i ? `ERR_OPEN :
                          input_short_i ? `ERR_SHORT : `ERR_MISMATCH;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sensor_err_ff <= 1'b0;
      err_code_ff <= `ERR_NONE;
    end else if (any_fault) begin
      // New fault wins over any clear
      sensor_err_ff <= 1'b1;
      err_code_ff <= fault_code;
    end else if (sensor_err_ff && sensor_in_limits_i && !lift_req) begin
      sensor_err_ff <= 1'b0;
      err_code_ff <= `ERR_NONE;
    end
  end

  wire lift_block = overload_ff | sensor_err_ff | overtemp_i;
  wire lower_block = overtemp_i;

  ////////////////////////////////////////////////////////////////////////////////
  // Motor management sequencer

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg dir_ff;
  reg nxt_dir;
  reg used_fast_ff;
  reg nxt_used_fast;
  reg [11:0] timer_ff;
  reg nxt_timer_clr;

  // Requests with their blocking applied; both directions at once means neither
  wire up_ok = lift_req & ~lower_req & ~lift_block;
  wire down_ok = lower_req & ~lift_req & ~lower_block;
  wire same_req = dir_ff ? down_ok : up_ok;
  wire other_req = dir_ff ? up_ok : down_ok;
  wire dir_block = dir_ff ? lower_block : lift_block;
  wire fast_eff = fast_raw & same_req;
  wire [11:0] off_len = used_fast_ff ? fast_off_time : slow_off_time;

  always @* begin
    nxt_state = state_ff;
    nxt_dir = dir_ff;
    nxt_used_fast = used_fast_ff;
    nxt_timer_clr = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (up_ok || down_ok) begin
          nxt_state = ST_SLOW;
          nxt_dir = down_ok;
          nxt_used_fast = 1'b0;
          nxt_timer_clr = 1'b1;
        end
      end
      ST_SLOW: begin
        if (!same_req || dir_block) begin
          nxt_state = ST_OFF;
          nxt_timer_clr = 1'b1;
        end else if (fast_eff && timer_ff >= slow_start_delay) begin
          nxt_state = ST_FAST;
          nxt_used_fast = 1'b1;
        end else if (!fast_eff) begin
          nxt_timer_clr = 1'b1;
        end
      end
      ST_FAST: begin
        if (dir_block) begin
          nxt_state = ST_OFF;
          nxt_timer_clr = 1'b1;
        end else if (!same_req) begin
          nxt_state = ST_STOP;
          nxt_timer_clr = 1'b1;
        end else if (!fast_eff) begin
          nxt_state = ST_SLOW;
          nxt_timer_clr = 1'b1;
        end
      end
      ST_STOP: begin
        if (dir_block || timer_ff >= slow_stop_delay) begin
          nxt_state = ST_OFF;
          nxt_timer_clr = 1'b1;
        end
      end
      ST_OFF: begin
        if (same_req && timer_ff >= off_len) begin
          nxt_state = ST_SLOW;
          nxt_used_fast = 1'b0;
          nxt_timer_clr = 1'b1;
        end else if (other_req && timer_ff >= reversal_off_time) begin
          nxt_state = ST_SLOW;
          nxt_dir = ~dir_ff;
          nxt_used_fast = 1'b0;
          nxt_timer_clr = 1'b1;
        end else if (!same_req && !other_req && timer_ff >= off_len &&
                     timer_ff >= reversal_off_time) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Relay outputs from the next state, gated by the blocking terms
  wire nxt_slow = nxt_state == ST_SLOW || nxt_state == ST_FAST || nxt_state == ST_STOP;
  wire nxt_fast = nxt_state == ST_FAST;
  reg [3:0] relay_ff;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      dir_ff <= 1'b0;
      used_fast_ff <= 1'b0;
      timer_ff <= 12'h000;
      relay_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      dir_ff <= nxt_dir;
      used_fast_ff <= nxt_used_fast;
      if (nxt_timer_clr) begin
        timer_ff <= 12'h000;
      end else if (tick_ff && timer_ff != 12'hFFF) begin
        timer_ff <= timer_ff + 12'h001;
      end
      relay_ff[0] <= nxt_slow & ~nxt_dir & ~lift_block;
      relay_ff[1] <= nxt_fast & ~nxt_dir & ~lift_block;
      relay_ff[2] <= nxt_slow & nxt_dir & ~lower_block;
      relay_ff[3] <= nxt_fast & nxt_dir & ~lower_block;
    end
  end

  assign lift_slow_o = relay_ff[0];
  assign lift_fast_o = relay_ff[1];
  assign lower_slow_o = relay_ff[2];
  assign lower_fast_o = relay_ff[3];

  ////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states, always OKAY

  reg wr_pend_ff;
  reg [7:0] wr_addr_ff;
  reg [31:0] rdata_ff;
  wire take = hsel_i & htrans_i[1] & hready_i;
  wire [7:0] a_off = haddr_i[7:0];
  wire hit_hi = haddr_i[31:8] == 24'h000000;
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h00000000;
    if (hit_hi) begin
      case (a_off)
        `REG_CTRL: rd_mux = {27'h0000000, ctrl_ff};
        `REG_STATUS: rd_mux = {21'h000000, state_ff, chan_diff, overtemp_i,
                               sensor_err_ff, overload_ff, relay_ff};
        `REG_ERROR: rd_mux = {30'h00000000, err_code_ff};
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      rdata_ff <= 32'h00000000;
      ctrl_ff <= `CTRL_RESET;
    end else begin
      if (wr_pend_ff && wr_addr_ff == `REG_CTRL) begin
        ctrl_ff <= hwdata_i[4:0];
      end
      if (hready_i) begin
        wr_pend_ff <= take & hwrite_i & hit_hi;
        wr_addr_ff <= a_off;
      end
      if (take && !hwrite_i) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  assign hrdata_o = rdata_ff;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

endmodule

// [verif/hoist_lift_safety_sequencer_tb_top.sv]
// Bench for the hoist sequencer: bus tasks, pendant model, one task per scenario.
// Assumes a 1 ms tick of 20 clocks and the checker bound to the design.
`timescale 1ns/1ps
`include "hoist_consts.vh"
module hoist_lift_safety_sequencer_tb_top;
  localparam int MS = 20;
  logic clk_i, rst_i, over_threshold_i, below_ack_level_i, cable_open_i, input_short_i;
  logic channel_mismatch_i, sensor_in_limits_i, overtemp_i, hsel_i, hwrite_i, chan_b_off;
  logic [1:0] htrans_i;
  logic [2:0] hsize_i, cmd;
  logic [31:0] haddr_i, hwdata_i, d;
  wire [31:0] hrdata_o;
  wire hreadyout_o, hresp_o, lift_req_a_i, lift_req_b_i, lower_req_a_i, lower_req_b_i;
  wire fast_req_i, lift_slow_o, lift_fast_o, lower_slow_o, lower_fast_o;
  wire [3:0] rly = {lower_fast_o, lower_slow_o, lift_fast_o, lift_slow_o};
  int fail_count, comparisons, n, k;
  hoist_pendant_model i_hoist_pendant_model (.clk_i(clk_i), .cmd_i(cmd), .chan_b_off_i(chan_b_off),
    .lift_a_o(lift_req_a_i), .lift_b_o(lift_req_b_i), .lower_a_o(lower_req_a_i),
    .lower_b_o(lower_req_b_i), .fast_o(fast_req_i));
  hoist_lift_safety_sequencer #(.MS_CYCLES(MS)) i_hoist_lift_safety_sequencer (.*,
    .hready_i(hreadyout_o));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task test_done;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task cyc(input int c);
    repeat (c) begin
      @(posedge clk_i);
    end
  endtask
  task bus_wait;
    int i;
    i = 0;
    do begin
      cyc(1);
      i++;
    end while (hreadyout_o !== 1'b1 && i < 50);
    if (hreadyout_o !== 1'b1) begin
      check("hready wait", hreadyout_o, 1'b1);
      test_done;
    end
  endtask
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel_i <= 1'b1;
    haddr_i <= a;
    hwrite_i <= wr;
    htrans_i <= 2'h2;
    bus_wait;
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    bus_wait;
    d = hrdata_o;
    check("okay response", hresp_o, 1'b0);
  endtask
  task wait_for(input int b, input logic v, input int lim);
    n = 0;
    while (rly[b] !== v && n < lim) begin
      cyc(1);
      n++;
    end
    if (rly[b] !== v) begin
      check("relay wait", rly[b], v);
      test_done;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_regs;
    bus(1'b0, `REG_CTRL, 32'h0);
    check("ctrl reset", d, 32'h0);
    bus(1'b1, `REG_CTRL, 32'h1F);
    bus(1'b0, `REG_CTRL, 32'h0);
    check("ctrl", d, 32'h1F);
    bus(1'b1, 32'h40, 32'hFFFFFFFF);
    bus(1'b0, 32'h40, 32'h0);
    check("unmapped", d, 32'h0);
    cmd <= 3'h1;
    cyc(40);
    check("fast alone", rly, 4'h0);
    chan_b_off <= 1'b1;
    cmd <= 3'h4;
    cyc(40);
    check("one channel", rly, 4'h0);
    bus(1'b0, `REG_STATUS, 32'h0);
    check("channel diff", d[`ST_CHAN_DIFF], 1'b1);
    chan_b_off <= 1'b0;
    cmd <= 3'h5;
    wait_for(0, 1'b1, 300 * MS);
    check("slow in time", n <= 300 * MS, 1'b1);
    cyc(3);
    check("lift both", rly, 4'h3);
    cmd <= 3'h0;
    wait_for(0, 1'b0, 100);
    $display("test regs and lift done");
  endtask
  task t_timing;
    bus(1'b1, `REG_CTRL, 32'h04);
    cmd <= 3'h5;
    wait_for(0, 1'b1, 400 * MS);
    wait_for(1, 1'b1, 400 * MS);
    check("start delay", n >= 290 * MS && n <= 310 * MS, 1'b1);
    cmd <= 3'h0;
    wait_for(1, 1'b0, 50);
    wait_for(0, 1'b0, 400 * MS);
    check("stop delay", n >= 290 * MS && n <= 310 * MS, 1'b1);
    cmd <= 3'h4;
    wait_for(0, 1'b1, 900 * MS);
    check("fast off time", n >= 740 * MS && n <= 760 * MS, 1'b1);
    bus(1'b1, `REG_CTRL, 32'h01);
    cmd <= 3'h2;
    wait_for(0, 1'b0, 50);
    wait_for(2, 1'b1, 600 * MS);
    check("reversal time", n >= 490 * MS && n <= 510 * MS, 1'b1);
    bus(1'b1, `REG_CTRL, 32'h1F);
    $display("test timing done");
  endtask
  task t_overload;
    over_threshold_i <= 1'b1;
    cyc(10);
    check("lift blocked", rly, 4'h0);
    bus(1'b0, `REG_STATUS, 32'h0);
    check("overload", d[`ST_OVERLOAD], 1'b1);
    over_threshold_i <= 1'b0;
    below_ack_level_i <= 1'b1;
    cmd <= 3'h2;
    wait_for(2, 1'b1, 1000 * MS);
    check("lower on overload", rly, 4'h4);
    cyc(1990 * MS - n);
    bus(1'b0, `REG_STATUS, 32'h0);
    check("overload held", d[`ST_OVERLOAD], 1'b1);
    cyc(20 * MS);
    bus(1'b0, `REG_STATUS, 32'h0);
    check("overload clear", d[`ST_OVERLOAD], 1'b0);
    cmd <= 3'h0;
    below_ack_level_i <= 1'b0;
    cyc(10);
    $display("test overload done");
  endtask
  task t_faults;
    for (k = 1; k <= 3; k++) begin
      cmd <= 3'h4;
      wait_for(0, 1'b1, 100 * MS);
      {channel_mismatch_i, input_short_i, cable_open_i} <= 3'h1 << (k - 1);
      cyc(10);
      check("fault lift", rly, 4'h0);
      bus(1'b0, `REG_ERROR, 32'h0);
      check("error code", d[1:0], k[1:0]);
      {channel_mismatch_i, input_short_i, cable_open_i} <= 3'h0;
      cyc(10);
      bus(1'b0, `REG_STATUS, 32'h0);
      check("error held", d[`ST_SENSOR_ERR], 1'b1);
      cmd <= 3'h0;
      cyc(10);
      bus(1'b0, `REG_STATUS, 32'h0);
      check("error clear", d[`ST_SENSOR_ERR], 1'b0);
    end
    cmd <= 3'h3;
    wait_for(3, 1'b1, 100 * MS);
    check("lower both", rly, 4'hC);
    overtemp_i <= 1'b1;
    cyc(10);
    check("overtemp", rly, 4'h0);
    overtemp_i <= 1'b0;
    cmd <= 3'h0;
    over_threshold_i <= 1'b1;
    cyc(795 * MS);
    bus(1'b0, `REG_STATUS, 32'h0);
    check("persist early", d[`ST_OVERLOAD], 1'b0);
    cyc(15 * MS);
    bus(1'b0, `REG_STATUS, 32'h0);
    check("persist late", d[`ST_OVERLOAD], 1'b1);
    $display("test faults done");
  endtask
  initial begin
    {rst_i, over_threshold_i, below_ack_level_i, cable_open_i} = 4'h8;
    {input_short_i, channel_mismatch_i, overtemp_i, hsel_i, hwrite_i} = 5'h00;
    sensor_in_limits_i = 1'b1;
    cmd = 3'h0;
    chan_b_off = 1'b0;
    htrans_i = 2'h0;
    hsize_i = 3'h2;
    haddr_i = 32'h0;
    hwdata_i = 32'h0;
    fail_count = 0;
    comparisons = 0;
    cyc(12);
    rst_i <= 1'b0;
    t_regs;
    t_timing;
    cmd <= 3'h4;
    wait_for(0, 1'b1, 1000 * MS);
    t_overload;
    t_faults;
    test_done;
  end
endmodule

// [verif/hoist_pendant_model.sv]
// Pendant model: one switch per direction feeding both request channels.
// Assumes bench commands; outputs change after rising edges.
`timescale 1ns/1ps
module hoist_pendant_model (
  input wire clk_i,
  input wire [2:0] cmd_i,
  input wire chan_b_off_i,
  output reg lift_a_o,
  output reg lift_b_o,
  output reg lower_a_o,
  output reg lower_b_o,
  output reg fast_o
);
  // Command bits: lift, lower, fast; channel B can be held off to split channels
  always @(posedge clk_i) begin
    lift_a_o <= cmd_i[2];
    lift_b_o <= cmd_i[2] & ~chan_b_off_i;
    lower_a_o <= cmd_i[1];
    lower_b_o <= cmd_i[1] & ~chan_b_off_i;
    fast_o <= cmd_i[0];
  end
endmodule

// [verif/hoist_seq_sva.sv]
// Checker for the hoist sequencer relay outputs.
// Assumes binding onto the top module; sees its ports only.
`timescale 1ns/1ps
module hoist_seq_sva (
  input wire clk_i,
  input wire rst_i,
  input wire lift_req_a_i,
  input wire lift_req_b_i,
  input wire over_threshold_i,
  input wire cable_open_i,
  input wire input_short_i,
  input wire channel_mismatch_i,
  input wire overtemp_i,
  input wire lift_slow_o,
  input wire lift_fast_o,
  input wire lower_slow_o,
  input wire lower_fast_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire lift_on = lift_req_a_i && lift_req_b_i;
  wire fault = cable_open_i || input_short_i || channel_mismatch_i;
  wire lift_any = lift_slow_o || lift_fast_o;
  wire lower_any = lower_slow_o || lower_fast_o;
  ////////////////////////////////////////////////////////////////////////////
  chk_lift_fast_pair: assert property (lift_fast_o |-> lift_slow_o)
    else $error("lift fast without lift slow");
  chk_lower_fast_pair: assert property (lower_fast_o |-> lower_slow_o)
    else $error("lower fast without lower slow");
  chk_fast_after_slow: assert property ($rose(lift_fast_o) |-> $past(lift_slow_o))
    else $error("lift fast came before lift slow");
  chk_fast_needs_lift: assert property ((!lift_on) [*6] |-> !lift_fast_o)
    else $error("lift fast without lift request");
  chk_overload_lift: assert property ((over_threshold_i && lift_on) [*4] |-> ##[0:3] !lift_any)
    else $error("lift not cut on overload");
  chk_fault_lift: assert property (fault [*2] |-> ##[0:3] !lift_any)
    else $error("lift not cut on sensor fault");
  chk_hot_lower: assert property (overtemp_i [*2] |-> ##[0:3] !lower_any)
    else $error("lower not cut on overtemperature");
  chk_one_direction: assert property (!(lift_any && lower_any))
    else $error("both directions driven");
endmodule
bind hoist_lift_safety_sequencer hoist_seq_sva i_hoist_seq_sva (.*);
